// ===== hdl/adc_port_map.svh
// Bit positions, edge counts and reset values of the conversion port
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

`define RESULT_W        12
`define EDGE_W          6
`define GRAY_W          6
`define FIFO_DEPTH      4
`define LEAD_ZEROS      6'h03
`define MSB_EDGE        6'h04
`define TRACK_EDGE      6'h0e
`define FRAME_EDGES     6'h10
`define EDGE_MAX        6'h3f
`define BIT_IDX_TOP     6'h0f
`define TRACK_RESET     1'b1
`define CAL_RESET       1'b1
`define OE_N_RESET      1'b1

`endif

// ===== hdl/adc_port_pkg.sv
// Types and gray-code functions of the conversion port; the sample buffer uses none of them
package adc_port_pkg;

	typedef enum logic [1:0] {
		POWER_NORMAL  = 2'b00,
		POWER_PARTIAL = 2'b01,
		POWER_FULL    = 2'b10
	} power_t;

	typedef struct packed {
		logic [1:0]  cnv_sync;
		logic        cnv_prev;
		logic [5:0]  rise_g1;
		logic [5:0]  rise_g2;
		logic [5:0]  fall_g1;
		logic [5:0]  fall_g2;
		logic [5:0]  rise_prev;
		logic [5:0]  fall_prev;
		logic [5:0]  rises;
		logic [5:0]  falls;
		logic        active;
		logic        release_armed;
		logic        track;
		power_t      power;
		logic        cal_pending;
		logic        calibrating;
		logic [11:0] shift;
		logic        dout;
		logic        dout_oe_n;
	} core_t;

	// Gray to binary for the edge counters crossing from the link clock
	function automatic logic [5:0] gray2bin(input logic [5:0] g);
		logic [5:0] b;
		b[5] = g[5];
		for (int i = 4; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction

	// Next gray code after g
	function automatic logic [5:0] gray_inc(input logic [5:0] g);
		logic [5:0] b;
		b = gray2bin(g) + 6'h01;
		return b ^ (b >> 1);
	endfunction

endpackage

// ===== hdl/adc_serial_conversion_port.sv
// Conversion control and serial readout of a 12-bit successive-approximation converter
//
// Contract
// - Falling convert start holds the sample, starts conversion, drives output low.
// - Sampling stage returns to tracking on the 14th rising serial edge.
// - After power-up the sampling stage tracks at once.
// - First conversion after power-up only calibrates; its result is discarded.
// - Output changes after rising edges: three zeros, then 12 bits MSB first.
// - Convert start rising between edges 14 and 16 keeps output driven.
// - Low at 16th falling edge: release output on next rising edge of either.
// - Convert start rising after edge 3, before edge 14, enters partial power-down.
// - Low for at least 14 serial cycles, then high, leaves power-down.
// - Repeating the power-down sequence in partial power-down enters full power-down.
// - Unipolar result is straight binary; bipolar result is two's complement.
// - One trailing zero follows the twelve result bits; with idle-high clock and strobe low the output is released at the 16th rise.
`timescale 1ns/1ns
`include "adc_port_map.svh"
module adc_serial_conversion_port #(
	parameter logic bipolar = 1'b0
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 sclk,
	input  wire logic                 convert_start_strobe,
	output logic                      dout,
	output logic                      dout_oe_n,
	input  wire logic                 result_valid,
	input  wire logic [`RESULT_W-1:0] result_data,
	output logic                      result_ready,
	output logic                      track_mode,
	output logic [1:0]                power_state,
	output logic                      calibrating
);

	////////////////////////////////////////////////////////////////////////////////
	// Link clock side: gray counters of rising and falling serial edges

	logic [`GRAY_W-1:0] rise_gray;
	logic [`GRAY_W-1:0] fall_gray;

	// Counts every rising serial edge; the host may stop the clock between frames
	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			rise_gray <= '0;
		end else begin
			rise_gray <= adc_port_pkg::gray_inc(rise_gray);
		end
	end

	// Counts every falling serial edge for the release decision
	always_ff @(negedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			fall_gray <= '0;
		end else begin
			fall_gray <= adc_port_pkg::gray_inc(fall_gray);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample buffer

	logic                 fifo_valid;
	logic [`RESULT_W-1:0] fifo_data;
	logic                 fifo_pop;

	sample_fifo #(
		.WIDTH (`RESULT_W),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (result_valid),
		.in_data   (result_data),
		.in_ready  (result_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Core side

	adc_port_pkg::core_t st;
	adc_port_pkg::core_t next_st;

	logic                 cnv;
	logic                 cnv_fell;
	logic                 cnv_rose;
	logic [`EDGE_W-1:0]   rise_bin;
	logic [`EDGE_W-1:0]   fall_bin;
	logic [`EDGE_W:0]     rise_sum;
	logic [`EDGE_W:0]     fall_sum;
	logic [`EDGE_W-1:0]   n_rise;
	logic [`EDGE_W-1:0]   n_fall;
	logic                 rise_seen;
	logic [`RESULT_W-1:0] coded;
	logic [`EDGE_W-1:0]   bit_pos;
	logic                 bit_val;

	// Edge events from the synchronised pins and counters
	always_comb begin
		cnv       = st.cnv_sync[1];
		cnv_fell  = st.cnv_prev & ~cnv;
		cnv_rose  = ~st.cnv_prev & cnv;
		rise_bin  = adc_port_pkg::gray2bin(st.rise_g2);
		fall_bin  = adc_port_pkg::gray2bin(st.fall_g2);
		rise_sum  = {1'b0, st.rises} + {1'b0, rise_bin - st.rise_prev};
		fall_sum  = {1'b0, st.falls} + {1'b0, fall_bin - st.fall_prev};
		n_rise    = rise_sum[`EDGE_W] ? `EDGE_MAX : rise_sum[`EDGE_W-1:0];
		n_fall    = fall_sum[`EDGE_W] ? `EDGE_MAX : fall_sum[`EDGE_W-1:0];
		rise_seen = rise_bin != st.rise_prev;
		fifo_pop  = cnv_fell & fifo_valid;
	end

	// Result coding of the variant and bit selection for the current edge
	always_comb begin
		coded   = bipolar ? {~fifo_data[`RESULT_W-1], fifo_data[`RESULT_W-2:0]}
		                  : fifo_data;
		bit_pos = `BIT_IDX_TOP - n_rise;
		if (n_rise >= `MSB_EDGE && n_rise < `FRAME_EDGES) begin
			bit_val = st.shift[bit_pos[3:0]];
		end else begin
			bit_val = 1'b0;
		end
	end

	// Next state of the conversion sequencer
	always_comb begin
		next_st           = st;
		next_st.cnv_sync  = {st.cnv_sync[0], convert_start_strobe};
		next_st.cnv_prev  = cnv;
		next_st.rise_g1   = rise_gray;
		next_st.rise_g2   = st.rise_g1;
		next_st.fall_g1   = fall_gray;
		next_st.fall_g2   = st.fall_g1;
		next_st.rise_prev = rise_bin;
		next_st.fall_prev = fall_bin;
		if (cnv_fell) begin
			// Hold the sample and start a frame with the output driven low
			next_st.rises         = '0;
			next_st.falls         = '0;
			next_st.active        = 1'b1;
			next_st.release_armed = 1'b0;
			next_st.track         = 1'b0;
			next_st.dout          = 1'b0;
			next_st.dout_oe_n     = 1'b0;
			next_st.shift         = fifo_valid ? coded : '0;
			next_st.calibrating   = st.cal_pending;
		end else if (st.active) begin
			next_st.rises = n_rise;
			next_st.falls = n_fall;
			// Sampling stage back to tracking for the next acquisition
			if (st.rises < `TRACK_EDGE && n_rise >= `TRACK_EDGE) begin
				next_st.track = 1'b1;
			end
			// A full frame ends the power-up calibration
			if (st.rises < `FRAME_EDGES && n_rise >= `FRAME_EDGES) begin
				next_st.cal_pending = 1'b0;
			end
			if (rise_seen) begin
				next_st.dout = bit_val;
			end
			// Still low at the 16th falling edge: arm the release
			if (st.falls < `FRAME_EDGES && n_fall >= `FRAME_EDGES && !cnv) begin
				next_st.release_armed = 1'b1;
			end
			if (st.release_armed && (rise_seen || cnv_rose)) begin
				next_st.dout_oe_n = 1'b1;
				next_st.active    = 1'b0;
				next_st.dout      = 1'b0;
				// A full frame with the strobe held low also wakes the converter
				next_st.power     = adc_port_pkg::POWER_NORMAL;
			end else if (cnv_rose) begin
				// Where the rise falls in the frame decides what it means
				if (n_rise >= `LEAD_ZEROS && n_rise < `TRACK_EDGE) begin
					next_st.dout_oe_n   = 1'b1;
					next_st.active      = 1'b0;
					next_st.dout        = 1'b0;
					next_st.track       = 1'b1;
					next_st.calibrating = 1'b0;
					unique case (st.power)
						adc_port_pkg::POWER_NORMAL: begin
							next_st.power = adc_port_pkg::POWER_PARTIAL;
						end
						adc_port_pkg::POWER_PARTIAL: begin
							next_st.power = adc_port_pkg::POWER_FULL;
						end
						adc_port_pkg::POWER_FULL: begin
							next_st.power = adc_port_pkg::POWER_FULL;
						end
						default: begin
							next_st.power = adc_port_pkg::POWER_NORMAL;
						end
					endcase
				end else if (n_rise >= `TRACK_EDGE) begin
					// Continuous mode keeps driving; also the way out of power-down
					next_st.power = adc_port_pkg::POWER_NORMAL;
					next_st.calibrating = 1'b0;
				end else begin
					// Aborted before the result began: drop the frame
					next_st.dout_oe_n   = 1'b1;
					next_st.active      = 1'b0;
					next_st.dout        = 1'b0;
					next_st.track       = 1'b1;
					next_st.calibrating = 1'b0;
				end
			end
		end
	end

	// State register; tracking starts at once after power-up
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st             <= '0;
			st.cnv_sync    <= 2'h3;
			st.cnv_prev    <= 1'b1;
			st.track       <= `TRACK_RESET;
			st.cal_pending <= `CAL_RESET;
			st.dout_oe_n   <= `OE_N_RESET;
			st.power       <= adc_port_pkg::POWER_NORMAL;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign dout        = st.dout;
	assign dout_oe_n   = st.dout_oe_n;
	assign track_mode  = st.track;
	assign power_state = st.power;
	assign calibrating = st.calibrating;

endmodule

// ===== hdl/sample_fifo.sv
// Small FIFO holding conversion results until a conversion frame takes one
`timescale 1ns/1ns
module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 count;
		logic                        not_full;
		logic                        not_empty;
	} fifo_t;

	fifo_t st;
	fifo_t next_st;
	logic  push;
	logic  pop;

	assign push      = in_valid & st.not_full;
	assign pop       = out_ready & st.not_empty;
	assign in_ready  = st.not_full;
	assign out_valid = st.not_empty;
	assign out_data  = st.mem[st.rd];

	// Pointers wrap by overflow, so DEPTH is kept a power of two
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr         = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		next_st.count     = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
		next_st.not_full  = next_st.count != (AW + 1)'(DEPTH);
		next_st.not_empty = next_st.count != '0;
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st          <= '0;
			st.not_full <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ===== verif/adc_port_checker.sv
// Timing checker for the serial conversion port
`timescale 1ns/1ns
module adc_port_checker #(
	parameter logic bipolar = 1'b0
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        sclk,
	input wire logic        convert_start_strobe,
	input wire logic        dout,
	input wire logic        dout_oe_n,
	input wire logic        result_valid,
	input wire logic [11:0] result_data,
	input wire logic        result_ready,
	input wire logic        track_mode,
	input wire logic [1:0]  power_state,
	input wire logic        calibrating
);
	logic [2:0] sync;
	logic [5:0] cnt;
	////////////////////////////////////////////////////////////////////////
	// Count synchronised serial rises since the last strobe fall
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync <= 3'h0;
			cnt <= 6'h00;
		end else begin
			sync <= {sync[1:0], sclk};
			if ($fell(convert_start_strobe)) begin
				cnt <= 6'h00;
			end else if (sync[1] && !sync[2] && cnt != 6'h3f) begin
				cnt <= cnt + 6'h01;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	property p_start;
		$fell(convert_start_strobe) |-> ##[1:6] (!dout_oe_n && !track_mode);
	endproperty
	a_start: assert property (p_start) else $error("no drive on start");
	property p_reset;
		$rose(reset_n) |-> track_mode && dout_oe_n && power_state == 2'b00;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_lead;
		!dout_oe_n && !convert_start_strobe && cnt < 6'h03 |-> !dout;
	endproperty
	a_lead: assert property (p_lead) else $error("lead bit not zero");
	property p_trail;
		!dout_oe_n && cnt > 6'h10 |-> !dout;
	endproperty
	a_trail: assert property (p_trail) else $error("trail bit not zero");
	property p_track;
		cnt == 6'h0e && $past(cnt) == 6'h0d |-> ##[0:4] track_mode;
	endproperty
	a_track: assert property (p_track) else $error("no tracking at 14");
	property p_release;
		cnt == 6'h11 && $past(cnt) == 6'h10 && !convert_start_strobe |-> ##[0:4] dout_oe_n;
	endproperty
	a_release: assert property (p_release) else $error("output not released");
	property p_cont;
		$rose(convert_start_strobe) && cnt > 6'h0d && cnt < 6'h10 |-> !dout_oe_n [*8];
	endproperty
	a_cont: assert property (p_cont) else $error("gap in continuous mode");
	property p_down;
		$rose(convert_start_strobe) && cnt > 6'h03 && cnt < 6'h0d
			|-> ##[1:6] dout_oe_n && power_state != 2'b00;
	endproperty
	a_down: assert property (p_down) else $error("no power-down");
	property p_wake;
		$rose(convert_start_strobe) && cnt > 6'h0d |-> ##[1:6] power_state == 2'b00;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
endmodule

bind adc_serial_conversion_port adc_port_checker #(.bipolar(bipolar)) adc_port_checker_i (
	.clk(clk), .reset_n(reset_n), .sclk(sclk), .convert_start_strobe(convert_start_strobe),
	.dout(dout), .dout_oe_n(dout_oe_n), .result_valid(result_valid),
	.result_data(result_data), .result_ready(result_ready), .track_mode(track_mode),
	.power_state(power_state), .calibrating(calibrating)
);

// ===== verif/host_model.sv
// Host model: drives strobe and serial clock, reads the data line
`timescale 1ns/1ns
module host_model (
	output logic      sclk,
	output logic      convert_start_strobe,
	input  wire logic dout,
	input  wire logic dout_oe_n
);
	initial begin
		sclk = 1'b0;
		convert_start_strobe = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// One frame of n rises; strobe returns high after rise up (0 = at end)
	task automatic frame(input int n, input int up, input logic idle, output logic [15:0] bits);
		// Off the core clock's edges, so the two clocks share no phase
		#1;
		sclk <= idle;
		#100;
		convert_start_strobe <= 1'b0;
		#40;
		for (int i = 1; i <= n; i++) begin
			sclk <= 1'b0;
			#40;
			sclk <= 1'b1;
			#20;
			bits = {bits[14:0], dout_oe_n ? 1'bx : dout};
			if (i == up) begin
				convert_start_strobe <= 1'b1;
			end
			#20;
		end
		sclk <= idle;
		#60;
		convert_start_strobe <= 1'b1;
	endtask
endmodule

// ===== verif/tb_adc_serial_conversion_port.sv
// Self-checking bench for the serial conversion port
`timescale 1ns/1ns
module tb_adc_serial_conversion_port;
	typedef struct packed {
		logic [11:0] data;
		logic        idle;
		logic [4:0]  up;
		logic        oe_n;
	} row_t;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        result_valid = 1'b0;
	logic [11:0] result_data = 12'h000;
	logic        sclk, convert_start_strobe, dout, dout_oe_n;
	logic        result_ready, track_mode, calibrating;
	logic [1:0]  power_state;
	logic [15:0] bits;
	logic        dout_bip, dout_oe_n_bip, ready_bip, track_bip, cal_bip;
	logic [1:0]  power_bip;
	logic [15:0] bits_bip;
	logic        last;
	int          errors = 0;
	int          total_checks = 0;
	row_t        rows [5] = '{'{12'hfff, 1'b0, 5'h0f, 1'b0}, '{12'ha5c, 1'b1, 5'h0e, 1'b0},
		'{12'h001, 1'b0, 5'h00, 1'b1}, '{12'h800, 1'b1, 5'h0f, 1'b0},
		'{12'h7fe, 1'b1, 5'h00, 1'b1}};
	logic [11:0] words [4] = '{12'h123, 12'h456, 12'h789, 12'habc};

	always #2 clk = ~clk;

	adc_serial_conversion_port adc_serial_conversion_port_i (
		.clk(clk), .reset_n(reset_n), .sclk(sclk), .convert_start_strobe(convert_start_strobe),
		.dout(dout), .dout_oe_n(dout_oe_n), .result_valid(result_valid),
		.result_data(result_data), .result_ready(result_ready), .track_mode(track_mode),
		.power_state(power_state), .calibrating(calibrating));
	host_model host_model_i (.sclk(sclk), .convert_start_strobe(convert_start_strobe),
		.dout(dout), .dout_oe_n(dout_oe_n));
	// Bipolar variant on the same pins, its line sampled as the host samples its own
	adc_serial_conversion_port #(.bipolar(1'b1)) adc_serial_conversion_port_bip_i (
		.clk(clk), .reset_n(reset_n), .sclk(sclk), .convert_start_strobe(convert_start_strobe),
		.dout(dout_bip), .dout_oe_n(dout_oe_n_bip), .result_valid(result_valid),
		.result_data(result_data), .result_ready(ready_bip), .track_mode(track_bip),
		.power_state(power_bip), .calibrating(cal_bip));
	always @(posedge sclk) begin
		#20;
		bits_bip <= {bits_bip[14:0], dout_oe_n_bip ? 1'bx : dout_bip};
	end
	////////////////////////////////////////////////////////////////////////
	// Compare tasks and verdict
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t bit %b exp %b", $time, got, exp);
		end
	endtask
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t word %h exp %h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Offer one word to the buffer and wait, bounded, until it is taken
	task automatic push(input logic [11:0] d);
		int k;
		k = 0;
		@(posedge clk);
		result_valid <= 1'b1;
		result_data <= d;
		do begin
			@(negedge clk);
			k++;
		end while (result_ready !== 1'b1 && k < 50);
		@(posedge clk);
		result_valid <= 1'b0;
		if (k == 50) begin
			errors++;
			summarize();
		end
	endtask
	task automatic conv(input int n, input int up, input logic idle);
		host_model_i.frame(n, up, idle, bits);
		repeat (6) @(posedge clk);
	endtask
	// First frame after reset is flagged as calibration
	task automatic cal_frame();
		fork
			host_model_i.frame(16, 0, 1'b0, bits);
			begin
				repeat (50) @(negedge clk);
				check_bit(calibrating, 1'b1);
			end
		join
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence: table of frames, then awkward cases
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		check_bit(track_mode, 1'b1);
		cal_frame();
		for (int i = 0; i < 5; i++) begin
			push(rows[i].data);
			conv(16, rows[i].up, rows[i].idle);
			// Idle-high clock puts the 16th fall before the 16th rise: with the strobe still low, line released there
			last = (rows[i].oe_n & rows[i].idle) ? 1'bx : 1'b0;
			check_word(bits, {3'h0, rows[i].data, last});
			check_word(bits_bip, {3'h0, rows[i].data ^ 12'h800, last});
			check_bit(dout_oe_n, rows[i].oe_n);
			check_bit(calibrating, 1'b0);
		end
		push(12'h3c3);
		host_model_i.frame(17, 0, 1'b0, bits);
		check_bit(dout_oe_n, 1'b1);
		// Fill until refused, offer one more, then drain with one frame more than the words held
		for (int i = 0; i < 4; i++) begin
			push(words[i]);
		end
		@(negedge clk);
		check_bit(result_ready, 1'b0);
		@(posedge clk);
		result_valid <= 1'b1;
		result_data <= 12'hbad;
		repeat (40) @(posedge clk);
		result_valid <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			conv(16, 15, 1'b1);
			check_word(bits, {3'h0, i < 4 ? words[i] : 12'h000, 1'b0});
		end
		conv(8, 8, 1'b0);
		check_word({14'h0000, power_state}, 16'h0001);
		check_bit(dout_oe_n, 1'b1);
		conv(8, 8, 1'b1);
		check_word({14'h0000, power_state}, 16'h0002);
		conv(16, 14, 1'b0);
		check_word({14'h0000, power_state}, 16'h0000);
		conv(8, 8, 1'b0);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		check_word({14'h0000, power_state}, 16'h0000);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		cal_frame();
		summarize();
	end
endmodule
